// >>> verilog/fbd_pkg.sv
// constants for the five-bit converter control block
package fbd_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] FBD_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] FBD_ADDR_LEVEL   = 4'h4;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int FBD_EN_BIT      = 7;
  localparam int FBD_PIN_ONE_BIT = 5;
  localparam int FBD_PIN_TWO_BIT = 4;
  localparam int FBD_POS_SEL_HI  = 3;
  localparam int FBD_POS_SEL_LO  = 2;
  localparam int FBD_NEG_SEL_HI  = 1;
  localparam int FBD_NEG_SEL_LO  = 0;
  localparam logic [7:0] FBD_CONTROL_MASK  = 8'hbf;
  localparam logic [7:0] FBD_LEVEL_MASK    = 8'h1f;
  localparam logic [7:0] FBD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FBD_LEVEL_RESET   = 8'h00;
  localparam int FBD_LEVEL_BITS = 5;
  // ----------------------------------------------------------------
  // source selector codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FBD_SRC_CODE0 = 2'h0;
  localparam logic [1:0] FBD_SRC_CODE1 = 2'h1;
  localparam logic [1:0] FBD_SRC_CODE2 = 2'h2;
  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] FBD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FBD_RESP_SLVERR = 2'h2;
endpackage : fbd_pkg

// >>> verilog/fbd_dac_control.sv
// five-bit converter control logic with axi4-lite register slave
`timescale 1ns/1ps
module fbd_dac_control
  import fbd_pkg::*;
#(
  parameter bit HAS_NEG_REF_B = 1'b0
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_active,
  input  wire logic        pin_one_digital_in,
  input  wire logic        pin_two_digital_in,
  output logic             converter_enable,
  output logic [4:0]       level_code,
  output logic             pos_sel_supply,
  output logic             pos_sel_ref_pin,
  output logic             pos_sel_fixed_reference,
  output logic             neg_sel_analog_ground,
  output logic             neg_sel_ref_pin_a,
  output logic             neg_sel_ref_pin_b,
  output logic             converter_pin_one,
  output logic             converter_pin_two,
  output logic             pin_one_digital_override,
  output logic             pin_two_digital_override,
  output logic             pin_one_read,
  output logic             pin_two_read
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]  control_reg;
  logic [7:0]  control_next;
  logic [7:0]  level_reg;
  logic [7:0]  level_next;
  logic        aw_held_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic        w_strb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  wire         aw_take    = s_axi_awvalid & s_axi_awready;
  wire         w_take     = s_axi_wvalid & s_axi_wready;
  wire         aw_have    = aw_held_reg | aw_take;
  wire         w_have     = w_held_reg | w_take;
  wire [3:0]   wr_addr    = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [7:0]   wr_byte    = w_held_reg ? w_data_reg[7:0] : s_axi_wdata[7:0];
  wire         wr_lane0   = w_held_reg ? w_strb0_reg : s_axi_wstrb[0];
  wire         wr_fire    = aw_have & w_have & ~bvalid_reg;
  wire         wr_hit_ctl = wr_addr == FBD_ADDR_CONTROL;
  wire         wr_hit_lvl = wr_addr == FBD_ADDR_LEVEL;
  wire         wr_ctl     = wr_fire & wr_hit_ctl & wr_lane0;
  wire         wr_lvl     = wr_fire & wr_hit_lvl & wr_lane0;
  wire [1:0]   wr_resp    = (wr_hit_ctl | wr_hit_lvl) ? FBD_RESP_OKAY : FBD_RESP_SLVERR;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // unimplemented bits masked off so they never store
  assign control_next = wr_ctl ? (wr_byte & FBD_CONTROL_MASK) : control_reg;
  assign level_next   = wr_lvl ? (wr_byte & FBD_LEVEL_MASK) : level_reg;

  // sleep_active deliberately unused: registers keep state and run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg <= FBD_CONTROL_RESET;
      level_reg   <= FBD_LEVEL_RESET;
    end
    else
    begin
      control_reg <= control_next;
      level_reg   <= level_next;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= FBD_RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_have & ~wr_fire;
      w_held_reg  <= w_have & ~wr_fire;
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_resp;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire         rd_take    = s_axi_arvalid & s_axi_arready;
  wire         rd_hit_ctl = s_axi_araddr == FBD_ADDR_CONTROL;
  wire         rd_hit_lvl = s_axi_araddr == FBD_ADDR_LEVEL;
  wire [31:0]  rd_word    = rd_hit_ctl ? {24'h00_0000, control_reg} :
                            rd_hit_lvl ? {24'h00_0000, level_reg} : 32'h0000_0000;
  wire [1:0]   rd_resp    = (rd_hit_ctl | rd_hit_lvl) ? FBD_RESP_OKAY : FBD_RESP_SLVERR;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= FBD_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // analog selection, straight from registers
  // ----------------------------------------------------------------
  wire [1:0] pos_sel = control_reg[FBD_POS_SEL_HI:FBD_POS_SEL_LO];
  wire [1:0] neg_sel = control_reg[FBD_NEG_SEL_HI:FBD_NEG_SEL_LO];

  assign converter_enable        = control_reg[FBD_EN_BIT];
  // ladder tap: vout = vneg + (vpos - vneg) * code / 2^5
  assign level_code              = level_reg[FBD_LEVEL_BITS-1:0];
  assign pos_sel_supply          = pos_sel == FBD_SRC_CODE0;
  assign pos_sel_ref_pin         = pos_sel == FBD_SRC_CODE1;
  assign pos_sel_fixed_reference = pos_sel == FBD_SRC_CODE2;
  assign neg_sel_analog_ground   = neg_sel == FBD_SRC_CODE0;
  assign neg_sel_ref_pin_a       = neg_sel == FBD_SRC_CODE1;
  assign neg_sel_ref_pin_b       = HAS_NEG_REF_B & (neg_sel == FBD_SRC_CODE2);

  // ----------------------------------------------------------------
  // pin routing and digital overrides
  // ----------------------------------------------------------------
  wire pin_one_output_enable = control_reg[FBD_PIN_ONE_BIT];
  wire pin_two_output_enable = control_reg[FBD_PIN_TWO_BIT];

  assign converter_pin_one        = pin_one_output_enable;
  assign converter_pin_two        = pin_two_output_enable;
  assign pin_one_digital_override = pin_one_output_enable;
  assign pin_two_digital_override = pin_two_output_enable;
  assign pin_one_read             = pin_one_digital_in & ~pin_one_output_enable;
  assign pin_two_read             = pin_two_digital_in & ~pin_two_output_enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_ENABLE_FOLLOWS_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> converter_enable == $past(wr_byte[FBD_EN_BIT])) else $error("enable does not follow bit 7");
  AST_LEVEL_WRITE_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lvl |=> level_code == $past(wr_byte[4:0])) else $error("level code not loaded");
  AST_LEVEL_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    level_reg[7:5] == 3'h0) else $error("level upper bits set");
  AST_PIN_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> converter_pin_one == $past(wr_byte[5])) else $error("pin one routing wrong");
  AST_PIN_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> converter_pin_two == $past(wr_byte[4])) else $error("pin two routing wrong");
  AST_OVERRIDE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> {pin_one_digital_override, pin_two_digital_override} == $past(wr_byte[5:4]))
    else $error("override mismatch");
  AST_READ_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (converter_pin_one |-> !pin_one_read) and (converter_pin_two |-> !pin_two_read))
    else $error("converter pin read not zero");
  AST_POS_ONEHOT: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_sel != 2'h3 |-> $onehot({pos_sel_supply, pos_sel_ref_pin, pos_sel_fixed_reference}))
    else $error("positive select decode wrong");
  AST_NEG_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    neg_sel == 2'h3 |-> !(neg_sel_analog_ground | neg_sel_ref_pin_a | neg_sel_ref_pin_b))
    else $error("reserved negative code selects a source");
  AST_HOLD_IN_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_active && !wr_ctl |=> $stable(control_reg)) else $error("control changed in sleep");
  AST_RESET_CLEARS: assert property (@(posedge aclk)
    !aresetn |=> control_reg == 8'h00 && level_reg == 8'h00) else $error("reset did not clear");
  AST_BIT6_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(rd_take && rd_hit_ctl) |-> !s_axi_rdata[6]) else $error("bit 6 reads one");
  AST_WRITE_READBACK: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> control_reg == ($past(wr_byte) & FBD_CONTROL_MASK)) else $error("control write lost");

  // ----------------------------------------------------------------
  // bus handshake, decode, pin read, reset and sleep checks
  // ----------------------------------------------------------------
  AST_BUSY_REFUSES_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_BUSY_REFUSES_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data missing or upper bits set");
  AST_READ_CONTROL: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && rd_hit_ctl |=> s_axi_rdata[7:0] == $past(control_reg))
    else $error("control readback wrong");
  AST_READ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && rd_hit_lvl |=> s_axi_rdata[7:0] == $past(level_reg))
    else $error("level readback wrong");
  AST_WRITE_BAD_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !(wr_hit_ctl || wr_hit_lvl) |=> s_axi_bresp == FBD_RESP_SLVERR && $stable(control_reg) && $stable(level_reg))
    else $error("unmapped write not refused");
  AST_READ_BAD_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && !(rd_hit_ctl || rd_hit_lvl) |=> s_axi_rresp == FBD_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_LANE_OFF_NO_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !wr_lane0 |=> $stable(control_reg) && $stable(level_reg))
    else $error("write stored with lane zero off");
  AST_SOURCE_WRITE_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> pos_sel == $past(wr_byte[FBD_POS_SEL_HI:FBD_POS_SEL_LO]) &&
               neg_sel == $past(wr_byte[FBD_NEG_SEL_HI:FBD_NEG_SEL_LO]))
    else $error("source select not loaded");
  AST_POS_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_sel == 2'h3 |-> !(pos_sel_supply || pos_sel_ref_pin || pos_sel_fixed_reference))
    else $error("reserved positive code selects a source");
  AST_NEG_B_ABSENT: assert property (@(posedge aclk) disable iff (!aresetn)
    !HAS_NEG_REF_B |-> !neg_sel_ref_pin_b)
    else $error("second negative pin selected where absent");
  AST_NEG_B_PRESENT: assert property (@(posedge aclk) disable iff (!aresetn)
    HAS_NEG_REF_B && neg_sel == FBD_SRC_CODE2 |-> neg_sel_ref_pin_b)
    else $error("second negative pin not selected");
  AST_READ_PASSES: assert property (@(posedge aclk) disable iff (!aresetn)
    !converter_pin_one |-> pin_one_read == pin_one_digital_in)
    else $error("released pin read blocked");
  AST_RESET_DISCONNECTS: assert property (@(posedge aclk)
    !aresetn |=> !converter_enable && !converter_pin_one && !converter_pin_two && level_code == 5'h00)
    else $error("reset left converter connected");
  AST_RESET_BUS_IDLE: assert property (@(posedge aclk)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset left a response pending");
  AST_LEVEL_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_active && !wr_lvl |=> $stable(level_reg))
    else $error("level changed in sleep");

endmodule : fbd_dac_control

// >>> sim/fbd_dac_control_test.sv
// self-checking bench for the five-bit converter control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module fbd_dac_control_test
  import fbd_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, sleep_active = 1'b0;
  logic        pin_one_digital_in = 1'b0, pin_two_digital_in = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [4:0]  level_code;
  logic        converter_enable, converter_pin_one, converter_pin_two, pin_one_read, pin_two_read;
  logic        pos_sel_supply, pos_sel_ref_pin, pos_sel_fixed_reference;
  logic        neg_sel_analog_ground, neg_sel_ref_pin_a, neg_sel_ref_pin_b;
  logic        pin_one_digital_override, pin_two_digital_override;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r_now;
  logic [1:0]  exp_b_now;
  logic        plain_ref_pin_b;
  int          n_fail = 0, n_tests = 0;
  logic [31:0] seed = 32'h0001_261a;

  always #25 aclk = ~aclk;

  fbd_dac_control #(.HAS_NEG_REF_B(1'b1)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_active, .pin_one_digital_in, .pin_two_digital_in, .converter_enable, .level_code,
    .pos_sel_supply, .pos_sel_ref_pin, .pos_sel_fixed_reference, .neg_sel_analog_ground,
    .neg_sel_ref_pin_a, .neg_sel_ref_pin_b, .converter_pin_one, .converter_pin_two,
    .pin_one_digital_override, .pin_two_digital_override, .pin_one_read, .pin_two_read);

  // default build without the second negative reference pin
  fbd_dac_control dut_plain (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .sleep_active, .pin_one_digital_in, .pin_two_digital_in, .converter_enable(), .level_code(),
    .pos_sel_supply(), .pos_sel_ref_pin(), .pos_sel_fixed_reference(), .neg_sel_analog_ground(),
    .neg_sel_ref_pin_a(), .neg_sel_ref_pin_b(plain_ref_pin_b), .converter_pin_one(), .converter_pin_two(),
    .pin_one_digital_override(), .pin_two_digital_override(), .pin_one_read(), .pin_two_read());

  // ----------------------------------------------------------------
  // response monitor
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      exp_r_now = (exp_r.size() > 0) ? exp_r.pop_front() : 34'h3_ffff_ffff;
      `CHK("read", exp_r_now, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      exp_b_now = (exp_b.size() > 0) ? exp_b.pop_front() : 2'h3;
      `CHK("bresp", exp_b_now, s_axi_bresp)
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic end_sim();
    n_fail += exp_r.size() + exp_b.size();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    int i;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (i == 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    int i;
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (i == 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask : rd

  task automatic chk_out(input logic [7:0] c, input logic [4:0] l);
    `CHK("enable", c[7], converter_enable)
    `CHK("level", l, level_code)
    `CHK("pin_one", c[5], converter_pin_one)
    `CHK("pin_two", c[4], converter_pin_two)
    `CHK("override", c[5:4], {pin_one_digital_override, pin_two_digital_override})
    `CHK("pin_read", {pin_one_digital_in & ~c[5], pin_two_digital_in & ~c[4]}, {pin_one_read, pin_two_read})
    `CHK("pos_sel", {c[3:2] == 2'h2, c[3:2] == 2'h1, c[3:2] == 2'h0}, {pos_sel_fixed_reference, pos_sel_ref_pin, pos_sel_supply})
    `CHK("neg_sel", {c[1:0] == 2'h2, c[1:0] == 2'h1, c[1:0] == 2'h0}, {neg_sel_ref_pin_b, neg_sel_ref_pin_a, neg_sel_analog_ground})
    `CHK("neg_b_absent", 1'b0, plain_ref_pin_b)
  endtask : chk_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [7:0]  c;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out(8'h00, 5'h00);
    rd(FBD_ADDR_CONTROL, {FBD_RESP_OKAY, 32'h0000_0000});
    wr(FBD_ADDR_CONTROL, 32'hffff_ffff, 4'hf, FBD_RESP_OKAY);
    rd(FBD_ADDR_CONTROL, {FBD_RESP_OKAY, 32'h0000_00bf});
    wr(FBD_ADDR_LEVEL, 32'hffff_ffff, 4'hf, FBD_RESP_OKAY);
    rd(FBD_ADDR_LEVEL, {FBD_RESP_OKAY, 32'h0000_001f});
    for (int k = 0; k < 16; k++)
    begin
      r = xs();
      c = {r[7], 1'b0, r[5:4], k[3:0]};
      sleep_active <= r[8];
      pin_one_digital_in <= r[9];
      pin_two_digital_in <= r[10];
      wr(FBD_ADDR_CONTROL, {r[31:8], c | {1'b0, r[6], 6'h00}}, 4'h1, FBD_RESP_OKAY);
      wr(FBD_ADDR_LEVEL, r, 4'h1, FBD_RESP_OKAY);
      chk_out(c, r[4:0]);
      rd(FBD_ADDR_CONTROL, {FBD_RESP_OKAY, 24'h00_0000, c});
      rd(FBD_ADDR_LEVEL, {FBD_RESP_OKAY, 27'h000_0000, r[4:0]});
    end
    wr(FBD_ADDR_LEVEL, 32'h0000_0000, 4'h0, FBD_RESP_OKAY);
    wr(4'h8, 32'h0000_0000, 4'hf, FBD_RESP_SLVERR);
    rd(4'hc, {FBD_RESP_SLVERR, 32'h0000_0000});
    c[FBD_EN_BIT] = 1'b0;
    wr(FBD_ADDR_CONTROL, {24'h00_0000, c}, 4'h1, FBD_RESP_OKAY);
    sleep_active <= 1'b1;
    repeat (3) @(posedge aclk);
    sleep_active <= 1'b0;
    @(posedge aclk);
    chk_out(c, r[4:0]);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out(8'h00, 5'h00);
    rd(FBD_ADDR_LEVEL, {FBD_RESP_OKAY, 32'h0000_0000});
    repeat (2) @(posedge aclk);
    end_sim();
  end
endmodule : fbd_dac_control_test
